// ==== cib_pkg.sv ====
// Purpose: Shared constants and types for the C/I channel handler.
// Assumes: Avalon-MM word registers, byte address = 4 * register index.
// Notes:   Frame slot positions count link bits after the frame sync.
package cib_pkg;

   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_CI0     = 8'h2E;
   localparam logic [7:0] IDX_CI1     = 8'h2F;
   localparam logic [7:0] IDX_MODE    = 8'h3C;
   localparam logic [7:0] IDX_IRQ_STA = 8'h3D;
   localparam logic [7:0] IDX_IRQ_MSK = 8'h3E;

   // Values after reset
   localparam logic [7:0] CI0_RX_RESET  = 8'hF3;
   localparam logic [7:0] CI0_TX_RESET  = 8'hFE;
   localparam logic [7:0] CI1_RX_RESET  = 8'hFE;
   localparam logic [7:0] CI1_TX_RESET  = 8'hFE;
   localparam logic [2:0] MODE_RESET    = 3'h0;
   localparam logic [2:0] IRQ_MSK_RESET = 3'h0;

   // Interface mode value that lets the request bit enter shared-bus arbitration; address 7 contends in every mode
   localparam logic [2:0] MODE_ARB_ON = 3'h1;
   localparam logic [2:0] ADDR_DEFAULT_OWNER = 3'h7;

   // Interrupt status bit positions
   localparam int IRQ_CH0 = 0;
   localparam int IRQ_CH1 = 1;
   localparam int IRQ_BAS = 2;
   localparam int IRQ_W   = 3;

   // Link frame slots
   localparam int         CNT_W      = 5;
   localparam logic [4:0] CNT_MAX    = 5'h1F;
   localparam logic [4:0] SLOT_CH0_L = 5'h03;
   localparam logic [4:0] SLOT_CH1_F = 5'h04;
   localparam logic [4:0] SLOT_CH1_L = 5'h09;
   localparam logic [4:0] SLOT_ARB_F = 5'h0A;
   localparam logic [4:0] SLOT_ARB_L = 5'h0C;
   localparam logic [4:0] SLOT_SG    = 5'h0D;

   typedef struct packed {
      logic [3:0] code;
      logic [2:0] addr;
      logic       req;
   } cib_tx0_s;

   typedef struct packed {
      logic [5:0] code;
      logic       width6;
      logic       irq_en;
   } cib_ch1_s;

   typedef struct packed {
      logic [3:0] code;
      logic       chg0;
      logic       chg1;
      logic       stop;
      logic       bus_access_state;
   } cib_rx0_s;

   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_RUN  = 2'b01,
      ARB_WON  = 2'b10
   } cib_arb_e;

endpackage

// ==== cib_ci_handler.sv ====
// Purpose: C/I channel 0/1 handler with shared-bus arbitration.
// Assumes: Link clock, frame sync and data are sampled by CLOCK.
// Notes:   Link data driven after link rising edge, sampled on falling.
//
// The implementer's own choice: the Avalon-MM register port.

module cib_ci_handler
(
   input  wire logic        CLOCK,
   input  wire logic        RST_B,
   input  wire logic [9:0]  ADDRESS,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [3:0]  BYTEENABLE,
   input  wire logic [31:0] WRITEDATA,
   output logic      [31:0] READDATA,
   output logic             WAITREQUEST,
   output logic             IRQ,
   input  wire logic        LINK_CLK,
   input  wire logic        FRAME_SYNC,
   input  wire logic        RX_DATA,
   input  wire logic        UP_DATA_I,
   output logic             UP_DATA_O,
   output logic             UP_DATA_OE_B
);

   logic [3:0]       meta_q;
   logic [3:0]       sync_q;
   logic             lclk_prev_q;
   logic             rise;
   logic             fall;
   logic             fsync_s;
   logic             rx_s;
   logic             wire_s;
   logic [4:0]       cnt_q;
   logic [4:0]       idx_d;

   logic             ack_q;
   logic             acc;
   logic             wr_acc;
   logic             rd_acc;
   logic [7:0]       reg_idx;
   logic             word_ok;
   logic [31:0]      rdata_q;
   logic [31:0]      rmux;

   cib_pkg::cib_tx0_s tx0_q;
   cib_pkg::cib_ch1_s tx1_q;
   logic [2:0]       mode_q;
   logic [2:0]       irq_sta_q;
   logic [2:0]       irq_msk_q;

   logic [3:0]       sh0_q;
   logic [3:0]       prev0_q;
   logic [3:0]       stable0_q;
   logic [3:0]       full0;
   logic             new0;
   logic [3:0]       code0_q;
   logic [3:0]       pend0_q;
   logic             pend_v_q;
   logic             read_done_q;
   logic             chg0_q;
   logic             chg0_set;
   logic             chg0_clr;

   logic [5:0]       sh1_q;
   logic [5:0]       full1;
   logic [5:0]       code1_q;
   logic             chg1_q;
   logic             new1;
   logic             stop_q;

   cib_pkg::cib_arb_e arb_q;
   logic [1:0]       arb_bit;
   logic             own_bit;
   logic             contend;
   logic             hold;
   logic             hold_prev_q;
   logic             tx_bit;
   logic             oe_b_q;
   cib_pkg::cib_rx0_s rx0;

   // Two flip-flops for every link input before any logic
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         meta_q      <= 4'hF;
         sync_q      <= 4'hF;
         lclk_prev_q <= 1'b1;
      end
      else
      begin
         meta_q      <= {LINK_CLK, FRAME_SYNC, RX_DATA, UP_DATA_I};
         sync_q      <= meta_q;
         lclk_prev_q <= sync_q[3];
      end
   end

   assign rise    = sync_q[3] & ~lclk_prev_q;
   assign fall    = ~sync_q[3] & lclk_prev_q;
   assign fsync_s = sync_q[2];
   assign rx_s    = sync_q[1];
   assign wire_s  = sync_q[0];

   always_comb
   begin
      if (fsync_s)
         idx_d = 5'h00;
      else if (cnt_q == cib_pkg::CNT_MAX)
         idx_d = cnt_q;
      else
         idx_d = cnt_q + 5'h01;
   end

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         cnt_q <= cib_pkg::CNT_MAX;
      else if (rise)
         cnt_q <= idx_d;
   end

   // Avalon-MM slave: one wait state per access
   assign WAITREQUEST = (READ | WRITE) & ~ack_q;
   assign acc     = (READ | WRITE) & ack_q;
   assign reg_idx = ADDRESS[9:2];
   assign word_ok = (ADDRESS[1:0] == 2'h0);
   assign wr_acc  = WRITE & ack_q & word_ok & BYTEENABLE[0];
   assign rd_acc  = READ & ack_q & word_ok;
   assign READDATA = rdata_q;

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         ack_q <= 1'b0;
      else
         ack_q <= (READ | WRITE) & ~ack_q;
   end

   assign rx0 = '{code: code0_q, chg0: chg0_q, chg1: chg1_q,
                  stop: stop_q, bus_access_state: ~hold};

   always_comb
   begin
      rmux = 32'h0000_0000;
      if (word_ok)
      begin
         case (reg_idx)
            cib_pkg::IDX_CI0:     rmux[7:0] = rx0;
            // Width select and irq enable read back
            // width read back
            cib_pkg::IDX_CI1:     rmux[7:0] = {code1_q, tx1_q.width6,
                                               tx1_q.irq_en};
            cib_pkg::IDX_MODE:    rmux[2:0] = mode_q;
            cib_pkg::IDX_IRQ_STA: rmux[2:0] = irq_sta_q;
            cib_pkg::IDX_IRQ_MSK: rmux[2:0] = irq_msk_q;
            default:              rmux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         rdata_q <= 32'h0000_0000;
      else if (READ & ~ack_q)
         rdata_q <= rmux;
   end

   // Control registers; mode and mask read back, CI1 only its width and enable bits, CI0 transmit is write-only
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         tx0_q     <= cib_pkg::CI0_TX_RESET;
         tx1_q     <= cib_pkg::CI1_TX_RESET;
         mode_q    <= cib_pkg::MODE_RESET;
         irq_msk_q <= cib_pkg::IRQ_MSK_RESET;
      end
      else if (wr_acc)
      begin
         case (reg_idx)
            cib_pkg::IDX_CI0:     tx0_q     <= WRITEDATA[7:0];
            cib_pkg::IDX_CI1:     tx1_q     <= WRITEDATA[7:0];
            cib_pkg::IDX_MODE:    mode_q    <= WRITEDATA[2:0];
            cib_pkg::IDX_IRQ_MSK: irq_msk_q <= WRITEDATA[2:0];
            default:              mode_q    <= mode_q;
         endcase
      end
   end

   // Channel 0 receive: stable across two frames
   assign full0 = {sh0_q[2:0], rx_s};
   assign new0  = fall & (cnt_q == cib_pkg::SLOT_CH0_L) &
                  (full0 == prev0_q) & (full0 != stable0_q);

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         sh0_q     <= 4'hF;
         prev0_q   <= 4'hF;
         stable0_q <= 4'hF;
      end
      else if (fall && cnt_q <= cib_pkg::SLOT_CH0_L)
      begin
         sh0_q <= full0;
         if (cnt_q == cib_pkg::SLOT_CH0_L)
         begin
            prev0_q <= full0;
            if (new0)
               stable0_q <= full0;
         end
      end
   end

   assign chg0_clr = rd_acc & (reg_idx == cib_pkg::IDX_CI0);

   // Visible code plus one pending code
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         code0_q     <= cib_pkg::CI0_RX_RESET[7:4];
         pend0_q     <= 4'hF;
         pend_v_q    <= 1'b0;
         read_done_q <= 1'b1;
      end
      else
      begin
         // load only after prior code read
         // keep first, overwrite pending with last
         if (new0 && (read_done_q || chg0_clr) && !pend_v_q)
         begin
            code0_q     <= full0;
            read_done_q <= 1'b0;
         end
         else if (chg0_clr && pend_v_q)
         begin
            code0_q     <= new0 ? full0 : pend0_q;
            pend_v_q    <= 1'b0;
            read_done_q <= 1'b0;
         end
         else if (new0)
         begin
            pend0_q  <= full0;
            pend_v_q <= 1'b1;
         end
         else if (chg0_clr)
            read_done_q <= 1'b1;
      end
   end

   assign chg0_set = (new0 && (read_done_q || chg0_clr) && !pend_v_q) ||
                     (chg0_clr && pend_v_q);

   // Set wins over the read clear
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         chg0_q <= 1'b0;
      // set on stable new code, cleared by read
      else if (chg0_set)
         chg0_q <= 1'b1;
      else if (chg0_clr)
         chg0_q <= 1'b0;
   end

   // Channel 1 receive: six bits every frame
   assign full1 = {sh1_q[4:0], rx_s};
   // upper bits ignored in 4-bit width
   assign new1 = fall & (cnt_q == cib_pkg::SLOT_CH1_L) &
                 (tx1_q.width6 ? (full1 != code1_q)
                               : (full1[3:0] != code1_q[3:0]));

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         sh1_q   <= 6'h3F;
         code1_q <= cib_pkg::CI1_RX_RESET[7:2];
      end
      else if (fall && cnt_q >= cib_pkg::SLOT_CH1_F &&
               cnt_q <= cib_pkg::SLOT_CH1_L)
      begin
         sh1_q <= full1;
         if (cnt_q == cib_pkg::SLOT_CH1_L)
            code1_q <= full1;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         chg1_q <= 1'b0;
      // single-frame change, cleared by ch0 read
      else if (new1)
         chg1_q <= 1'b1;
      else if (chg0_clr)
         chg1_q <= 1'b0;
   end

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         stop_q <= cib_pkg::CI0_RX_RESET[1];
      else if (fall && cnt_q == cib_pkg::SLOT_SG)
         stop_q <= rx_s;
   end

   // Shared-bus arbitration, open drain, lower address wins
   // request contends without a pending frame
   assign contend = (tx0_q.req && mode_q == cib_pkg::MODE_ARB_ON) ||
                    (tx0_q.addr == cib_pkg::ADDR_DEFAULT_OWNER);
   assign arb_bit = 2'(cib_pkg::SLOT_ARB_L - cnt_q);
   assign own_bit = tx0_q.addr[arb_bit];
   assign hold    = (arb_q == cib_pkg::ARB_WON);

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         arb_q <= cib_pkg::ARB_IDLE;
      else if (rise && idx_d == cib_pkg::SLOT_ARB_F)
         arb_q <= contend ? cib_pkg::ARB_RUN : cib_pkg::ARB_IDLE;
      else if (fall && arb_q == cib_pkg::ARB_RUN &&
               cnt_q >= cib_pkg::SLOT_ARB_F &&
               cnt_q <= cib_pkg::SLOT_ARB_L)
      begin
         // compare own address bit with wire
         case ({wire_s != own_bit, cnt_q == cib_pkg::SLOT_ARB_L})
            2'b00:   arb_q <= cib_pkg::ARB_RUN;
            2'b01:   arb_q <= cib_pkg::ARB_WON;
            default: arb_q <= cib_pkg::ARB_IDLE;
         endcase
      end
   end

   // Upstream bit for the slot now starting
   always_comb
   begin
      tx_bit = 1'b1;
      if (idx_d <= cib_pkg::SLOT_CH0_L)
         // ch0 code only while holding bus
         tx_bit = hold ? tx0_q.code[2'(cib_pkg::SLOT_CH0_L - idx_d)]
                       : 1'b1;
      else if (idx_d <= cib_pkg::SLOT_CH1_L)
         tx_bit = tx1_q.code[3'(cib_pkg::SLOT_CH1_L - idx_d)];
      else if (idx_d <= cib_pkg::SLOT_ARB_L &&
               (idx_d == cib_pkg::SLOT_ARB_F ? contend
                                             : arb_q == cib_pkg::ARB_RUN))
         tx_bit = tx0_q.addr[2'(cib_pkg::SLOT_ARB_L - idx_d)];
   end

   // Ones are sent by releasing the open-drain line
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         oe_b_q <= 1'b1;
      else if (rise)
         oe_b_q <= tx_bit;
   end

   assign UP_DATA_O    = 1'b0;
   assign UP_DATA_OE_B = oe_b_q;

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         irq_sta_q   <= 3'h0;
         hold_prev_q <= 1'b0;
      end
      else
      begin
         hold_prev_q <= hold;
         irq_sta_q   <= (irq_sta_q &
                         ~((wr_acc && reg_idx == cib_pkg::IDX_IRQ_STA) ?
                           WRITEDATA[2:0] : 3'h0)) |
                        {hold != hold_prev_q,
                         new1 & tx1_q.irq_en,
                         chg0_set};
      end
   end

   // Level interrupt from unmasked status
   assign IRQ = |(irq_sta_q & irq_msk_q);

endmodule

// ==== cib_ci_handler_asserts.sv ====
// Purpose: Port assertions for the C/I channel handler.
// Assumes: One clock domain, RST_B async active low.
// Notes:   Attached to every handler by bind.
module cib_ci_handler_asserts
(
   input wire logic        CLOCK,
   input wire logic        RST_B,
   input wire logic [9:0]  ADDRESS,
   input wire logic        READ,
   input wire logic        WRITE,
   input wire logic [3:0]  BYTEENABLE,
   input wire logic [31:0] WRITEDATA,
   input wire logic [31:0] READDATA,
   input wire logic        WAITREQUEST,
   input wire logic        IRQ,
   input wire logic        LINK_CLK,
   input wire logic        UP_DATA_OE_B
);
   default clocking dc @(posedge CLOCK);
   endclocking
   default disable iff (!RST_B);
   logic       acc;
   logic       wr_acc;
   logic [1:0] ci1_transmit_control_q;
   assign acc = (READ | WRITE) & ~WAITREQUEST;
   assign wr_acc = WRITE & acc;
   // Shadow of written ch1 width and enable
   always_ff @(posedge CLOCK or negedge RST_B)
      if (!RST_B)
         ci1_transmit_control_q <= 2'h2;
      else if (wr_acc && ADDRESS == 10'h0BC && BYTEENABLE[0])
         ci1_transmit_control_q <= WRITEDATA[1:0];
   sequence s_wait;
      (READ | WRITE) & WAITREQUEST;
   endsequence
   sequence s_ack;
      acc;
   endsequence
   a_one_wait: assert property (s_wait |=> s_ack)
      else $error("bus request not answered after one wait");
   a_idle_ready: assert property (!(READ | WRITE) |-> !WAITREQUEST)
      else $error("wait raised with no request");
   a_unmapped_zero: assert property (READ && acc && !(ADDRESS inside
      {10'h0B8, 10'h0BC, 10'h0F0, 10'h0F4, 10'h0F8}) |-> READDATA == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (READ && acc |-> READDATA[31:8] == 24'h0)
      else $error("read data above register width not zero");
   a_ch1_echo: assert property (
      READ && acc && ADDRESS == 10'h0BC |-> READDATA[1:0] == ci1_transmit_control_q)
      else $error("ch1 width or enable not read back");
   a_mask_quiet: assert property (wr_acc && ADDRESS == 10'h0F8 &&
      BYTEENABLE[0] && WRITEDATA[2:0] == 3'h0 |=> !IRQ [*2])
      else $error("interrupt high with all sources masked");
   a_irq_fall: assert property ($fell(IRQ) |-> $past(wr_acc))
      else $error("interrupt dropped without a register write");
   a_oe_on_link: assert property (
      $changed(UP_DATA_OE_B) |-> $past(LINK_CLK, 2))
      else $error("upstream drive changed away from a link bit");
endmodule

bind cib_ci_handler cib_ci_handler_asserts u_chk (.*);

// ==== cib_link_model.sv ====
// Purpose: Other terminal-bus device and link clock source.
// Assumes: Upstream wire is wired-AND with a pull-up.
// Notes:   Link clock stands still between frames.
module cib_link_model
(
   output logic      LINK_CLK,
   output logic      FRAME_SYNC,
   output logic      RX_DATA,
   output wire logic UP_DATA_I,
   input  wire logic UP_DATA_O,
   input  wire logic UP_DATA_OE_B
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        pull_q;
   logic [31:0] up_q;
   // Released wire reads one unless some party pulls low
   assign UP_DATA_I = (UP_DATA_OE_B | UP_DATA_O) & pull_q;
   initial
   begin
      LINK_CLK = 1'b0;
      FRAME_SYNC = 1'b0;
      RX_DATA = 1'b1;
      pull_q = 1'b1;
      up_q = 32'hFFFFFFFF;
   end
   // low address wins, 7 never pulls
   task automatic frame(input logic [3:0] c0, input logic [5:0] c1,
                        input logic [3:0] arb, input logic sg);
      logic [31:0] bits;
      bits = {c0, c1, arb[2:0], sg, 18'h3FFFF};
      // Keep link edges off the CLOCK sampling edge
      #2;
      FRAME_SYNC = 1'b1;
      #16;
      for (int i = 0; i < 32; i++)
      begin
         LINK_CLK = 1'b1;
         RX_DATA = bits[31-i];
         pull_q = !(arb[3] && i >= 10 && i <= 12) || bits[31-i];
         #32;
         LINK_CLK = 1'b0;
         FRAME_SYNC = 1'b0;
         #32;
         up_q[31-i] = UP_DATA_I;
      end
      pull_q = 1'b1;
      RX_DATA = !RX_DATA;
   endtask
endmodule

// ==== cib_ci_handler_tb.sv ====
// Purpose: Self-checking bench for the C/I channel handler.
// Assumes: Register answer comes after one wait state.
// Notes:   Frames come from the terminal-bus model.
module cib_ci_handler_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLOCK;
   logic        RST_B;
   logic [9:0]  ADDRESS;
   logic        READ;
   logic        WRITE;
   logic [3:0]  BYTEENABLE;
   logic [31:0] WRITEDATA;
   wire  [31:0] READDATA;
   wire         WAITREQUEST;
   wire         IRQ;
   wire         LINK_CLK;
   wire         FRAME_SYNC;
   wire         RX_DATA;
   wire         UP_DATA_I;
   wire         UP_DATA_O;
   wire         UP_DATA_OE_B;
   int          fails;
   int          samples_checked;
   logic [7:0]  rd;
   wire  [31:0] up;
   assign up = u_link.up_q;
   cib_ci_handler dut (.*);
   cib_link_model u_link (.*);
   initial
   begin
      CLOCK = 1'b0;
      forever #4 CLOCK = ~CLOCK;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd);
      int n;
      ADDRESS <= {idx, 2'h0};
      READ <= !wr;
      WRITE <= wr;
      WRITEDATA <= {24'h0, wd};
      n = 0;
      @(posedge CLOCK);
      // Read before this edge's updates, as the slave samples it
      while (WAITREQUEST !== 1'b0 && n < 50)
      begin
         @(posedge CLOCK);
         n++;
      end
      if (n == 50)
         fails++;
      rd = READDATA[7:0];
      READ <= 1'b0;
      WRITE <= 1'b0;
      @(posedge CLOCK);
   endtask
   task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check(rd, exp);
   endtask
   task automatic fr(input logic [3:0] c0, input logic [5:0] c1,
                     input logic [3:0] arb, input logic sg);
      u_link.frame(c0, c1, arb, sg);
      repeat (8) @(posedge CLOCK);
   endtask
   task automatic t_reset();
      rc(cib_pkg::IDX_CI0, cib_pkg::CI0_RX_RESET);
      rc(cib_pkg::IDX_CI1, cib_pkg::CI1_RX_RESET);
      rc(cib_pkg::IDX_MODE, 8'h00);
      rc(cib_pkg::IDX_IRQ_MSK, 8'h00);
      rc(8'h10, 8'h00);
      check({7'h0, IRQ}, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_ch0();
      fr(4'h5, 6'h3F, 4'h0, 1'b0);
      rc(cib_pkg::IDX_CI0, 8'hF0);
      fr(4'h5, 6'h3F, 4'h0, 1'b0);
      rc(cib_pkg::IDX_CI0, 8'h58);
      rc(cib_pkg::IDX_CI0, 8'h50);
      check({4'h0, up[31:28]}, 8'h0F);
      rc(cib_pkg::IDX_IRQ_STA, 8'h05);
      check({7'h0, IRQ}, 8'h00);
      bus(1'b1, cib_pkg::IDX_IRQ_MSK, 8'h01);
      check({7'h0, IRQ}, 8'h01);
      bus(1'b1, cib_pkg::IDX_IRQ_MSK, 8'h00);
      check({7'h0, IRQ}, 8'h00);
      bus(1'b1, cib_pkg::IDX_IRQ_STA, 8'h07);
      rc(cib_pkg::IDX_IRQ_STA, 8'h00);
      check({7'h0, IRQ}, 8'h00);
      $display("t_ch0 done");
   endtask
   task automatic t_burst();
      for (int i = 1; i < 4; i++)
      begin
         fr(4'(i), 6'h3F, 4'h0, 1'b0);
         fr(4'(i), 6'h3F, 4'h0, 1'b0);
      end
      rc(cib_pkg::IDX_CI0, 8'h18);
      rc(cib_pkg::IDX_CI0, 8'h38);
      rc(cib_pkg::IDX_CI0, 8'h30);
      $display("t_burst done");
   endtask
   task automatic t_ch1();
      bus(1'b1, cib_pkg::IDX_CI1, 8'hFD);
      rc(cib_pkg::IDX_CI1, 8'hFD);
      fr(4'h3, 6'h0F, 4'h0, 1'b0);
      rc(cib_pkg::IDX_CI0, 8'h30);
      fr(4'h3, 6'h0E, 4'h0, 1'b0);
      rc(cib_pkg::IDX_CI0, 8'h34);
      rc(cib_pkg::IDX_CI1, 8'h39);
      rc(cib_pkg::IDX_IRQ_STA, 8'h07);
      bus(1'b1, cib_pkg::IDX_IRQ_STA, 8'h07);
      bus(1'b1, cib_pkg::IDX_CI1, 8'hFE);
      fr(4'h3, 6'h2E, 4'h0, 1'b0);
      rc(cib_pkg::IDX_CI0, 8'h34);
      rc(cib_pkg::IDX_IRQ_STA, 8'h04);
      $display("t_ch1 done");
   endtask
   task automatic t_tx();
      bus(1'b1, cib_pkg::IDX_CI0, 8'hAE);
      bus(1'b1, cib_pkg::IDX_CI1, 8'h96);
      fr(4'h3, 6'h2E, 4'h0, 1'b0);
      check({4'h0, up[31:28]}, 8'h0A);
      check({2'h0, up[27:22]}, 8'h25);
      fr(4'h3, 6'h2E, 4'hB, 1'b0);
      fr(4'h3, 6'h2E, 4'hB, 1'b0);
      check({4'h0, up[31:28]}, 8'h0F);
      rc(cib_pkg::IDX_CI0, 8'h31);
      bus(1'b1, cib_pkg::IDX_CI0, 8'hA5);
      fr(4'h3, 6'h2E, 4'hB, 1'b0);
      check({5'h0, up[21:19]}, 8'h03);
      bus(1'b1, cib_pkg::IDX_MODE, 8'h01);
      fr(4'h3, 6'h2E, 4'hB, 1'b0);
      check({5'h0, up[21:19]}, 8'h02);
      fr(4'h3, 6'h2E, 4'h0, 1'b0);
      check({4'h0, up[31:28]}, 8'h0A);
      rc(cib_pkg::IDX_CI0, 8'h30);
      bus(1'b1, cib_pkg::IDX_CI0, 8'hA4);
      fr(4'h3, 6'h2E, 4'hB, 1'b1);
      rc(cib_pkg::IDX_CI0, 8'h33);
      $display("t_tx done");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // About 18 frames of 2 us each; allow ample margin
   initial
   begin
      #200000;
      fails++;
      finish_test();
   end
   initial
   begin
      RST_B = 1'b0;
      READ = 1'b0;
      WRITE = 1'b0;
      ADDRESS = 10'h000;
      BYTEENABLE = 4'hF;
      WRITEDATA = 32'h0;
      fails = 0;
      samples_checked = 0;
      repeat (8) @(posedge CLOCK);
      RST_B <= 1'b1;
      @(posedge CLOCK);
      t_reset();
      t_ch0();
      t_burst();
      t_ch1();
      t_tx();
      finish_test();
   end
endmodule
